// >>> core/rail_enable_defs.svh
/*
 * Register offsets, field positions, used-bit masks and timing counts for the
 * rail enable sequencing block.
 * Assumes a 200 MHz core clock and a byte-wide register port.
 */
`ifndef RAIL_ENABLE_DEFS_SVH
`define RAIL_ENABLE_DEFS_SVH

`define OFF_CONV6_EDGE_DELAY   8'h18
`define OFF_LSW_POWER_GOOD_FLAG_MASK     8'h19
`define OFF_LSW_ENABLE_SELECT  8'h1A

`define FALL_DELAY_HI          5
`define FALL_DELAY_LO          3
`define RISE_DELAY_HI          2
`define RISE_DELAY_LO          0
`define PG_THRESH_HI           6
`define PG_THRESH_LO           5
`define EN_SOURCE_HI           4
`define EN_SOURCE_LO           2
`define MASK_SHARED_BIT        1
`define MASK_SECOND_BIT        0

`define CONV6_EDGE_DELAY_USED  8'h3F
`define LSW_SELECT_USED        8'h7F

`define CLK_FREQ_KHZ           200000
`define MS_TICK_CYCLES         (`CLK_FREQ_KHZ)

`endif

// >>> core/rail_enable_pkg.sv
/*
 * Types for the rail enable sequencing block.
 * Assumes rail_enable_defs.svh supplies the numbers.
 */
package rail_enable_pkg;
    typedef enum logic [1:0] {
        PG_1V5,
        PG_1V8,
        PG_2V5,
        PG_3V3
    } pg_threshold_t;

    typedef enum logic [2:0] {
        SRC_CONTROL_INPUT_1,
        SRC_CONTROL_INPUT_2,
        SRC_CONTROL_INPUT_5,
        SRC_CONTROL_INPUT_4,
        SRC_CONTROL_INPUT_3,
        SRC_CONTROL_INPUT_3_AND_4,
        SRC_CONTROL_INPUT_6,
        SRC_ALWAYS
    } en_source_t;

    typedef enum logic [1:0] {
        DLY_IDLE,
        DLY_RISE,
        DLY_FALL
    } delay_state_t;
endpackage

// >>> core/edge_delay_if.sv
/*
 * Interface carrying the enable and delay codes to the edge delay unit.
 * Assumes all users share core_clk.
 */
`timescale 1ns/1ps
interface edge_delay_if;
    logic       en_in;
    logic [2:0] rise_code;
    logic [2:0] fall_code;
    logic       ms_tick;
    logic       en_out;
    modport ctrl  (output en_in, output rise_code, output fall_code, output ms_tick,
                   input en_out);
    modport delay (input en_in, input rise_code, input fall_code, input ms_tick,
                   output en_out);
endinterface

// >>> core/edge_delay_unit.sv
/*
 * Delays rising and falling edges of an enable by coded millisecond counts.
 * Assumes a one-cycle millisecond tick from the parent.
 */
`timescale 1ns/1ps
`include "rail_enable_defs.svh"
module edge_delay_unit (
    input  wire logic  core_clk,
    input  wire logic  resetn,
    edge_delay_if.delay dl
);
    rail_enable_pkg::delay_state_t state_q, state_d;
    logic [6:0] count_q, count_d;
    logic       out_q,   out_d;

    // Code to delay in ms
    function automatic logic [6:0] code_ms(input logic [2:0] code);
        case (code)
            3'h0: code_ms = 7'h00;
            3'h1: code_ms = 7'h02;
            3'h2: code_ms = 7'h04;
            3'h3: code_ms = 7'h08;
            3'h4: code_ms = 7'h10;
            3'h5: code_ms = 7'h18;
            3'h6: code_ms = 7'h20;
            default: code_ms = 7'h40;
        endcase
    endfunction

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        out_d   = out_q;
        case (state_q)
            rail_enable_pkg::DLY_IDLE: begin
                if (dl.en_in && !out_q) begin
                    count_d = code_ms(dl.rise_code);
                    if (code_ms(dl.rise_code) == 7'h00) begin
                        out_d = 1'b1;
                    end else begin
                        state_d = rail_enable_pkg::DLY_RISE;
                    end
                end else if (!dl.en_in && out_q) begin
                    count_d = code_ms(dl.fall_code);
                    if (code_ms(dl.fall_code) == 7'h00) begin
                        out_d = 1'b0;
                    end else begin
                        state_d = rail_enable_pkg::DLY_FALL;
                    end
                end
            end
            rail_enable_pkg::DLY_RISE: begin
                if (!dl.en_in) begin
                    state_d = rail_enable_pkg::DLY_IDLE;
                end else if (dl.ms_tick) begin
                    count_d = count_q - 7'h01;
                    if (count_q == 7'h01) begin
                        out_d   = 1'b1;
                        state_d = rail_enable_pkg::DLY_IDLE;
                    end
                end
            end
            rail_enable_pkg::DLY_FALL: begin
                if (dl.en_in) begin
                    state_d = rail_enable_pkg::DLY_IDLE;
                end else if (dl.ms_tick) begin
                    count_d = count_q - 7'h01;
                    if (count_q == 7'h01) begin
                        out_d   = 1'b0;
                        state_d = rail_enable_pkg::DLY_IDLE;
                    end
                end
            end
            default: state_d = rail_enable_pkg::DLY_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= rail_enable_pkg::DLY_IDLE;
            count_q <= 7'h00;
            out_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            out_q   <= out_d;
        end
    end

    assign dl.en_out = out_q;
endmodule

// >>> core/rail_enable_sequencing.sv
/*
 * Rail enable sequencing: converter six edge delays and load switch A
 * enable logic, with a byte register port and OTP default load.
 * Assumes control inputs and power-good flags are asynchronous pins and
 * that OTP defaults are stable when otp_valid rises.
 */
`timescale 1ns/1ps
`include "rail_enable_defs.svh"
module rail_enable_sequencing #(
    parameter int MS_CYCLES = `MS_TICK_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] otp_conv6_edge_delay,
    input  wire logic [7:0] otp_lsw_power_good_flag_mask,
    input  wire logic [7:0] otp_lsw_enable_select,
    input  wire logic       otp_valid,
    input  wire logic [6:1] control_input,
    input  wire logic       converter_six_enable_req,
    input  wire logic [7:0] rail_power_good_flag,
    input  wire logic       shared_switch_linear_pg,
    input  wire logic       load_switch_b_pg,
    output logic            converter_six_enable,
    output logic            load_switch_a_enable,
    output logic      [1:0] load_switch_pg_threshold,
    output logic            config_loaded
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [9:0] pin_meta_q, pin_sync_q;
    logic [9:0] pin_raw;
    logic [7:0] flag_meta_q, flag_sync_q;
    // Bit 0 pads the word so control inputs keep their numbers
    assign pin_raw = {load_switch_b_pg, shared_switch_linear_pg,
                      converter_six_enable_req, control_input, 1'b0};

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta_q  <= 10'h000;
            pin_sync_q  <= 10'h000;
            flag_meta_q <= 8'h00;
            flag_sync_q <= 8'h00;
        end else begin
            pin_meta_q  <= pin_raw;
            pin_sync_q  <= pin_meta_q;
            flag_meta_q <= rail_power_good_flag;
            flag_sync_q <= flag_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers, loaded from OTP then written by software
    logic [7:0] edge_delay_q,   edge_delay_d;
    logic [7:0] power_good_flag_mask_q,   power_good_flag_mask_d;
    logic [7:0] enable_sel_q,   enable_sel_d;
    logic       loaded_q,       loaded_d;
    logic [7:0] rdata_q,        rdata_d;

    // Register index of a byte address, 2'h3 when unmapped
    function automatic logic [1:0] reg_index(input logic [7:0] addr);
        if (addr == `OFF_CONV6_EDGE_DELAY) begin
            reg_index = 2'h0;
        end else if (addr == `OFF_LSW_POWER_GOOD_FLAG_MASK) begin
            reg_index = 2'h1;
        end else if (addr == `OFF_LSW_ENABLE_SELECT) begin
            reg_index = 2'h2;
        end else begin
            reg_index = 2'h3;
        end
    endfunction

    // Reserved bits are held at zero in every path
    always_comb begin
        edge_delay_d = edge_delay_q;
        power_good_flag_mask_d = power_good_flag_mask_q;
        enable_sel_d = enable_sel_q;
        loaded_d     = loaded_q;
        rdata_d      = rdata_q;
        // Defaults land once, on the first valid cycle after reset
        if (!loaded_q) begin
            if (otp_valid) begin
                edge_delay_d = otp_conv6_edge_delay & `CONV6_EDGE_DELAY_USED;
                power_good_flag_mask_d = otp_lsw_power_good_flag_mask;
                enable_sel_d = otp_lsw_enable_select & `LSW_SELECT_USED;
                loaded_d     = 1'b1;
            end
        end else if (reg_write) begin
            if (reg_index(reg_addr) == 2'h0) begin
                edge_delay_d = reg_wdata & `CONV6_EDGE_DELAY_USED;
            end else if (reg_index(reg_addr) == 2'h1) begin
                power_good_flag_mask_d = reg_wdata;
            end else if (reg_index(reg_addr) == 2'h2) begin
                enable_sel_d = reg_wdata & `LSW_SELECT_USED;
            end
        end
        if (reg_read) begin
            if (reg_index(reg_addr) == 2'h0) begin
                rdata_d = edge_delay_q;
            end else if (reg_index(reg_addr) == 2'h1) begin
                rdata_d = power_good_flag_mask_q;
            end else if (reg_index(reg_addr) == 2'h2) begin
                rdata_d = enable_sel_q;
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            edge_delay_q <= 8'h00;
            power_good_flag_mask_q <= 8'h00;
            enable_sel_q <= 8'h00;
            loaded_q     <= 1'b0;
            rdata_q      <= 8'h00;
        end else begin
            edge_delay_q <= edge_delay_d;
            power_good_flag_mask_q <= power_good_flag_mask_d;
            enable_sel_q <= enable_sel_d;
            loaded_q     <= loaded_d;
            rdata_q      <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick divider, restarted on every request edge
    logic [31:0] div_q, div_d;
    logic        tick_q, tick_d;
    logic        req_prev_q, req_prev_d;
    logic        req_on;

    // Restart keeps each delay a whole number of periods
    always_comb begin
        req_on     = pin_sync_q[7] & loaded_q;
        req_prev_d = req_on;
        tick_d     = 1'b0;
        div_d      = div_q + 32'h1;
        if (req_on != req_prev_q) begin
            div_d = 32'h0;
        end else if (div_q == 32'(MS_CYCLES - 1)) begin
            div_d  = 32'h0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            div_q      <= 32'h0;
            tick_q     <= 1'b0;
            req_prev_q <= 1'b0;
        end else begin
            div_q      <= div_d;
            tick_q     <= tick_d;
            req_prev_q <= req_prev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter six edge delay
    edge_delay_if c6_if ();
    // Request waits for the defaults
    assign c6_if.en_in     = req_on;
    assign c6_if.rise_code = edge_delay_q[`RISE_DELAY_HI:`RISE_DELAY_LO];
    assign c6_if.fall_code = edge_delay_q[`FALL_DELAY_HI:`FALL_DELAY_LO];
    assign c6_if.ms_tick   = tick_q;

    edge_delay_unit u_conv6_delay (
        .core_clk (core_clk),
        .resetn   (resetn),
        .dl       (c6_if.delay)
    );

    ////////////////////////////////////////////////////////////////////////
    // Load switch A enable
    // Control selector: picks the enable source of the load switch
    function automatic logic select_source(input logic [2:0] code, input logic [6:1] ctl);
        case (rail_enable_pkg::en_source_t'(code))
            rail_enable_pkg::SRC_CONTROL_INPUT_1:       select_source = ctl[1];
            rail_enable_pkg::SRC_CONTROL_INPUT_2:       select_source = ctl[2];
            rail_enable_pkg::SRC_CONTROL_INPUT_5:       select_source = ctl[5];
            rail_enable_pkg::SRC_CONTROL_INPUT_4:       select_source = ctl[4];
            rail_enable_pkg::SRC_CONTROL_INPUT_3:       select_source = ctl[3];
            rail_enable_pkg::SRC_CONTROL_INPUT_3_AND_4: select_source = ctl[3] & ctl[4];
            rail_enable_pkg::SRC_CONTROL_INPUT_6:       select_source = ctl[6];
            default:                         select_source = 1'b1;
        endcase
    endfunction

    logic lsw_en_q, lsw_en_d;
    // Extra flop so the delayed enable leaves from a register
    logic c6_en_q;
    logic src_on, pg_ok;

    // Flag order: linear three, linear two, converters six to one
    always_comb begin
        src_on = select_source(enable_sel_q[`EN_SOURCE_HI:`EN_SOURCE_LO], pin_sync_q[6:1]);
        pg_ok  = &(flag_sync_q | power_good_flag_mask_q)
               & (pin_sync_q[8] | enable_sel_q[`MASK_SHARED_BIT])
               & (pin_sync_q[9] | enable_sel_q[`MASK_SECOND_BIT]);
        lsw_en_d = loaded_q & src_on & pg_ok;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lsw_en_q <= 1'b0;
            c6_en_q  <= 1'b0;
        end else begin
            lsw_en_q <= lsw_en_d;
            c6_en_q  <= c6_if.en_out;
        end
    end

    assign reg_rdata                = rdata_q;
    assign converter_six_enable     = c6_en_q;
    assign load_switch_a_enable     = lsw_en_q;
    assign load_switch_pg_threshold = enable_sel_q[`PG_THRESH_HI:`PG_THRESH_LO];
    assign config_loaded            = loaded_q;
endmodule

// >>> bench/rail_enable_chk.sv
/* Port checker for the rail enable sequencing top.
   Assumes one clock domain; bound to every instance of the design top. */
`timescale 1ns/1ps
module rail_enable_chk (
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       otp_valid,
    input wire logic [6:1] control_input,
    input wire logic       converter_six_enable_req,
    input wire logic [7:0] rail_power_good_flag,
    input wire logic       shared_switch_linear_pg,
    input wire logic       load_switch_b_pg,
    input wire logic       converter_six_enable,
    input wire logic       load_switch_a_enable,
    input wire logic [1:0] load_switch_pg_threshold,
    input wire logic       config_loaded
);
    logic [3:0] lo_q;
    logic [3:0] hi_q;
    logic [3:0] quiet_q;
    // Saturating counts of request low, request high, and no stimulus
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lo_q    <= 4'h0;
            hi_q    <= 4'h0;
            quiet_q <= 4'h0;
        end else begin
            lo_q    <= converter_six_enable_req ? 4'h0 : lo_q + {3'h0, lo_q != 4'hF};
            hi_q    <= !converter_six_enable_req ? 4'h0 : hi_q + {3'h0, hi_q != 4'hF};
            quiet_q <= (reg_write || !config_loaded || $changed(control_input)
                        || $changed({rail_power_good_flag, shared_switch_linear_pg,
                                     load_switch_b_pg})) ? 4'h0
                       : quiet_q + {3'h0, quiet_q != 4'hF};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence rd_of(logic [7:0] a);
        reg_read && !reg_write && reg_addr == a;
    endsequence
    rsv_delay_a: assert property (rd_of(8'h18) |=> reg_rdata[7:6] == 2'h0)
        else $error("delay register reserved bits read nonzero");
    rsv_select_a: assert property (rd_of(8'h1A) |=> !reg_rdata[7])
        else $error("select register reserved bit read nonzero");
    thr_read_a: assert property (
        rd_of(8'h1A) ##0 config_loaded |=> reg_rdata[6:5] == load_switch_pg_threshold)
        else $error("threshold output differs from its register field");
    thr_change_a: assert property (
        $changed(load_switch_pg_threshold) |-> $past(reg_write) || !$past(config_loaded))
        else $error("threshold changed without a write or default load");
    gate_en_a: assert property (
        !config_loaded |-> !load_switch_a_enable && !converter_six_enable)
        else $error("enable driven before defaults loaded");
    load_done_a: assert property (otp_valid && !config_loaded |=> config_loaded)
        else $error("defaults not loaded one edge after valid");
    load_hold_a: assert property (config_loaded |=> config_loaded)
        else $error("loaded flag dropped outside reset");
    no_rise_a: assert property (lo_q >= 4'h8 |-> !$rose(converter_six_enable))
        else $error("converter six enable rose with request long low");
    no_fall_a: assert property (hi_q >= 4'h8 |-> !$fell(converter_six_enable))
        else $error("converter six enable fell with request long high");
    lsw_quiet_a: assert property (quiet_q >= 4'h6 |-> $stable(load_switch_a_enable))
        else $error("load switch enable moved without a cause");
endmodule
bind rail_enable_sequencing rail_enable_chk rail_enable_chk_i (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .otp_valid(otp_valid),
    .control_input(control_input), .converter_six_enable_req(converter_six_enable_req),
    .rail_power_good_flag(rail_power_good_flag),
    .shared_switch_linear_pg(shared_switch_linear_pg), .load_switch_b_pg(load_switch_b_pg),
    .converter_six_enable(converter_six_enable), .load_switch_a_enable(load_switch_a_enable),
    .load_switch_pg_threshold(load_switch_pg_threshold), .config_loaded(config_loaded));

// >>> bench/host_pins.sv
/* Host pin model: control inputs, converter six request, power-good flags.
   Assumes its tasks are called just after a falling clock edge. */
`timescale 1ns/1ps
module host_pins (
    output logic [6:1] control_input,
    output logic       converter_six_enable_req,
    output logic [7:0] rail_power_good_flag,
    output logic       shared_switch_linear_pg,
    output logic       load_switch_b_pg
);
    initial begin
        control_input = 6'h00;
        converter_six_enable_req = 1'b0;
        {rail_power_good_flag, shared_switch_linear_pg, load_switch_b_pg} = 10'h3FF;
    end
    task automatic set_ctl(input logic [6:1] v);
        control_input = v;
    endtask
    task automatic set_req(input logic v);
        converter_six_enable_req = v;
    endtask
    task automatic set_pg(input logic [9:0] v);
        {rail_power_good_flag, shared_switch_linear_pg, load_switch_b_pg} = v;
    endtask
endmodule

// >>> bench/rail_enable_sequencing_tb.sv
/* Self-checking bench for rail enable sequencing.
   Assumes host_pins drives the pins and the checker is bound. */
`timescale 1ns/1ps
module rail_enable_sequencing_tb;
    localparam int MS = 10;
    logic       core_clk = 1'b0;
    logic       resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read = 1'b0;
    logic       otp_valid = 1'b0;
    logic [7:0] reg_rdata;
    logic [6:1] control_input;
    logic       converter_six_enable_req;
    logic [7:0] rail_power_good_flag;
    logic       shared_switch_linear_pg;
    logic       load_switch_b_pg;
    logic       converter_six_enable;
    logic       load_switch_a_enable;
    logic [1:0] load_switch_pg_threshold;
    logic       config_loaded;
    logic [9:0] m;
    int         fail_count = 0;
    int         n_compared = 0;
    int         cyc;
    int         ms_tab [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
    logic [6:1] sel_tab [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20, 6'h00};

    always #2.5 core_clk = ~core_clk;

    host_pins host_pins_i (.control_input(control_input),
        .converter_six_enable_req(converter_six_enable_req),
        .rail_power_good_flag(rail_power_good_flag),
        .shared_switch_linear_pg(shared_switch_linear_pg), .load_switch_b_pg(load_switch_b_pg));
    rail_enable_sequencing #(.MS_CYCLES(MS)) rail_enable_sequencing_i (
        .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .otp_conv6_edge_delay(8'hC9), .otp_lsw_power_good_flag_mask(8'h5A),
        .otp_lsw_enable_select(8'hFE), .otp_valid(otp_valid), .control_input(control_input),
        .converter_six_enable_req(converter_six_enable_req),
        .rail_power_good_flag(rail_power_good_flag),
        .shared_switch_linear_pg(shared_switch_linear_pg), .load_switch_b_pg(load_switch_b_pg),
        .converter_six_enable(converter_six_enable), .load_switch_a_enable(load_switch_a_enable),
        .load_switch_pg_threshold(load_switch_pg_threshold), .config_loaded(config_loaded));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge core_clk);
        reg_write = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge core_clk);
        reg_read = 1'b0;
        @(negedge core_clk);
        chk("reg_rdata", exp, reg_rdata);
    endtask
    task automatic lsw_chk(input logic [9:0] pg, input logic [6:1] pins, input logic exp);
        host_pins_i.set_pg(pg);
        host_pins_i.set_ctl(pins);
        repeat (6) @(negedge core_clk);
        chk("load_switch_a_enable", {7'h00, exp}, {7'h00, load_switch_a_enable});
    endtask
    // Edge time is whole ticks plus the synchroniser and output flops
    task automatic edge_chk(input logic v, input int ms);
        host_pins_i.set_req(v);
        cyc = 0;
        while (converter_six_enable !== v && cyc < 700) begin
            @(negedge core_clk);
            cyc++;
        end
        chk("converter_six_delay", 8'h01,
            {7'h00, cyc >= ms * MS && cyc <= ms * MS + 8});
        if (cyc >= 700)
            report_and_stop();
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge core_clk);
        resetn = 1'b1;
        wr(8'h19, 8'hFF);
        rd_chk(8'h19, 8'h00);
        chk("config_loaded", 8'h00, {7'h00, config_loaded});
        otp_valid = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("config_loaded", 8'h01, {7'h00, config_loaded});
        rd_chk(8'h18, 8'h09);
        rd_chk(8'h19, 8'h5A);
        rd_chk(8'h1A, 8'h7E);
        rd_chk(8'h1B, 8'h00);
        for (int t = 0; t < 4; t++) begin
            wr(8'h1A, {1'b1, t[1:0], 5'h1C});
            rd_chk(8'h1A, {1'b0, t[1:0], 5'h1C});
            chk("pg_threshold", {6'h00, t[1:0]}, {6'h00, load_switch_pg_threshold});
        end
        wr(8'h19, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(8'h1A, {3'h0, c[2:0], 2'h0});
            lsw_chk(10'h3FF, sel_tab[c], 1'b1);
            lsw_chk(10'h3FF, ~sel_tab[c], c == 7);
            lsw_chk(10'h3FF, sel_tab[c] & (sel_tab[c] - 6'h01), c == 7);
        end
        for (int i = 0; i < 10; i++) begin
            m = 10'h001 << i;
            lsw_chk(~m, 6'h00, 1'b0);
            wr(8'h19, m[9:2]);
            wr(8'h1A, {6'h07, m[1:0]});
            lsw_chk(~m, 6'h00, 1'b1);
            wr(8'h19, 8'h00);
            wr(8'h1A, 8'h1C);
        end
        for (int c = 0; c < 8; c++) begin
            wr(8'h18, {2'h0, c[2:0], c[2:0]});
            edge_chk(1'b1, ms_tab[c]);
            edge_chk(1'b0, ms_tab[c]);
        end
        // Mid-run reset brings back the defaults over software values
        @(negedge core_clk);
        resetn = 1'b0;
        repeat (12) @(negedge core_clk);
        chk("config_loaded", 8'h00, {7'h00, config_loaded});
        resetn = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("config_loaded", 8'h01, {7'h00, config_loaded});
        rd_chk(8'h18, 8'h09);
        report_and_stop();
    end
endmodule
